// *** hw/mfs_acc_lane.v ***
// Purpose: per-channel accumulate-and-dump lane, one interface slice
// Assumes: channel index from the sequencer, in step with the sample
// Notes: stands in for the filter arithmetic; sums rate samples per channel
`timescale 1ns/1ps
`include "mfs_consts.vh"

module mfs_acc_lane (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Sample in
  input wire take,
  input wire dump,
  input wire [`MFS_CH_W-1:0] chan,
  input wire signed [`MFS_IN_W-1:0] sample,
  // Result
  output reg signed [`MFS_OUT_W-1:0] result_reg
);

  // =====================================================
  // Per-channel store
  reg signed [`MFS_OUT_W-1:0] acc_mem [0:`MFS_CH_PER_IF-1];
  wire signed [`MFS_OUT_W-1:0] sum_w;
  integer i;

  assign sum_w = acc_mem[chan] + sample;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      for (i = 0; i < `MFS_CH_PER_IF; i = i + 1) begin
        acc_mem[i] <= {`MFS_OUT_W{1'b0}};
      end
      result_reg <= {`MFS_OUT_W{1'b0}};
    end else if (take) begin
      if (dump) begin
        acc_mem[chan] <= {`MFS_OUT_W{1'b0}};
        result_reg <= sum_w;
      end else begin
        acc_mem[chan] <= sum_w;
      end
    end
  end

endmodule

// *** hw/mfs_consts.vh ***
// Purpose: shared constants of the multichannel filter stream port logic
// Assumes: single clock, one channel sequence per packet
// Notes: widths fixed at build values
`ifndef MFS_CONSTS_VH
`define MFS_CONSTS_VH

// =====================================================
// Build shape
`define MFS_NUM_IF 2
`define MFS_CH_PER_IF 4
`define MFS_CH_W 2
`define MFS_MAX_CH_TOTAL 1024
`define MFS_IN_W 16
`define MFS_OUT_W 16
`define MFS_RATE_W 3
`define MFS_RATE_MIN 3'h2

// =====================================================
// Error codes
`define MFS_ERR_NONE 2'h0
`define MFS_ERR_NO_SOP 2'h1
`define MFS_ERR_NO_EOP 2'h2
`define MFS_ERR_OTHER 2'h3

// =====================================================
// Channel and phase constants
`define MFS_CH_ZERO 2'h0
`define MFS_CH_LAST 2'h3
`define MFS_PH_ZERO 3'h0
`define MFS_PH_ONE 3'h1

`endif

// *** hw/mfs_frame_check.v ***
// Purpose: packet framing checker for the sink port
// Assumes: packet spans channels 0 to last, sop on 0 and eop on last
// Notes: reports a code per accepted beat; upstream code wins if nonzero
`timescale 1ns/1ps
`include "mfs_consts.vh"

module mfs_frame_check (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Accepted beat
  input wire take,
  input wire sop,
  input wire eop,
  input wire [1:0] err_in,
  // Sequencing
  output reg [`MFS_CH_W-1:0] chan_reg,
  output reg [1:0] err_code
);

  wire at_last;
  reg [`MFS_CH_W-1:0] chan_next;

  assign at_last = (chan_reg == `MFS_CH_LAST);

  // Error code for this beat
  always @* begin
    err_code = `MFS_ERR_NONE;
    if (err_in != `MFS_ERR_NONE) begin
      err_code = err_in;
    end else if (eop && !at_last && !sop) begin
      err_code = `MFS_ERR_OTHER;
    end else if (at_last && !eop) begin
      err_code = `MFS_ERR_NO_EOP;
    end else if (chan_reg == `MFS_CH_ZERO && !sop) begin
      err_code = `MFS_ERR_NO_SOP;
    end
  end

  // Sop forces channel 0; eop or last channel wraps
  always @* begin
    chan_next = chan_reg;
    if (take) begin
      if (eop || (sop ? (`MFS_CH_ZERO == `MFS_CH_LAST) : at_last)) begin
        chan_next = `MFS_CH_ZERO;
      end else if (sop) begin
        chan_next = `MFS_CH_ZERO + 2'h1;
      end else begin
        chan_next = chan_reg + 2'h1;
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan_reg <= `MFS_CH_ZERO;
    end else begin
      chan_reg <= chan_next;
    end
  end

endmodule

// *** hw/mfs_stream_top.v ***
// Purpose: stream sink and source ports of a multichannel decimator
// Assumes: many inputs one output build, zero ready latency both sides
// Notes: one output beat carries all interfaces; channel = sample slot
//
// Operation
// [R1] Both ports accept a beat in the same cycle ready and valid are high.
// [R2] A beat moves only when both ready and valid are high.
// [R3] A stalled source holds its data and valid until ready.
// [R4] Sink carries one symbol per interface; source carries one per beat; here each output beat carries one symbol per interface.
// [R5] Interface 0 sits in the most significant slice of a combined bus.
// [R6] Input error codes: 00 none, 01 no sop, 10 no eop, 11 other.
// [R7] Output error uses same codes; other faults are marked 11.
// [R8] All registers run on the single clock; clock enable is optional.
// [R9] Controlling logic resets the block before presenting samples.
// [R10] Source raises input eop with the last channel's sample.
// [R11] A sample with input sop belongs to channel 0.
// [R12] With input valid low, processing halts until valid returns.
// [R13] Source never asserts valid while clock enable is low.
// [R14] Input ready is high only when a sample can be accepted.
// [R15] Each result carries the channel index it belongs to.
// [R16] Output sop is high exactly for channel 0 results.
// [R17] Output eop is high exactly for last-channel results.
// [R18] Downstream drives output ready to apply backpressure.
// [R19] Output valid is high only while a result is held.
// [R20] Rate input picks the decimation factor and may change at run time.
// [R21] Interfaces times channels per interface may not exceed 1024.
// [R22] Reset clears filter state and sequencing and holds output valid low.
`timescale 1ns/1ps
`include "mfs_consts.vh"

module mfs_stream_top (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Rate select
  input wire [`MFS_RATE_W-1:0] rate,
  // Sink port
  input wire [`MFS_NUM_IF*`MFS_IN_W-1:0] combined_input_bus,
  input wire in_valid,
  input wire in_sop,
  input wire in_eop,
  input wire [1:0] in_error,
  output wire in_ready,
  // Source port
  output wire [`MFS_NUM_IF*`MFS_OUT_W-1:0] combined_output_bus,
  output reg [`MFS_CH_W-1:0] out_channel_reg,
  output reg out_sop_reg,
  output reg out_eop_reg,
  output reg [1:0] out_error_reg,
  output reg out_valid_reg,
  input wire out_ready
);

  // =====================================================
  // Build check
  localparam TOTAL_CH = `MFS_NUM_IF * `MFS_CH_PER_IF;
  localparam BUILD_OK = (TOTAL_CH <= `MFS_MAX_CH_TOTAL) ? 1 : 0; // R21
  // Width of this check wire comes from the product limit check
  wire [BUILD_OK-1:0] build_ok_w; // R21
  assign build_ok_w = 1'b1;

  // =====================================================
  // Handshake
  wire take;
  wire dump;
  wire out_fire;
  wire out_free;
  wire [`MFS_CH_W-1:0] chan;
  wire [1:0] beat_err;

  assign out_fire = out_valid_reg & out_ready; // R1 R2
  // Room if output empty or draining this cycle; zero ready latency
  assign out_free = !out_valid_reg | out_ready; // R1
  // Input only stalls when a dump has no place to go
  assign in_ready = out_free | !dump; // R14
  assign take = in_valid & in_ready; // R2 R12

  // =====================================================
  // Rate phase
  // Phase advances once per packet; rate sampled on the last beat of a decimation period
  reg [`MFS_RATE_W-1:0] phase_reg;
  reg [`MFS_RATE_W-1:0] phase_next;
  reg [`MFS_RATE_W-1:0] rate_reg;
  reg [`MFS_RATE_W-1:0] rate_next;
  wire pkt_end;
  wire [`MFS_RATE_W-1:0] rate_eff;

  // Below-minimum factors are clamped rather than stalling the chain
  assign rate_eff = (rate < `MFS_RATE_MIN) ? `MFS_RATE_MIN : rate; // R20
  assign pkt_end = (chan == `MFS_CH_LAST) | in_eop; // R10
  assign dump = (phase_reg == rate_reg - `MFS_PH_ONE);

  always @* begin
    phase_next = phase_reg;
    rate_next = rate_reg;
    if (take && pkt_end) begin // R12
      if (dump) begin
        phase_next = `MFS_PH_ZERO;
        rate_next = rate_eff; // R20
      end else begin
        phase_next = phase_reg + `MFS_PH_ONE;
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin // R8
    if (rst) begin
      phase_reg <= `MFS_PH_ZERO; // R22
      rate_reg <= `MFS_RATE_MIN;
    end else begin
      phase_reg <= phase_next;
      rate_reg <= rate_next;
    end
  end

  // =====================================================
  // Framing and channel sequencing
  mfs_frame_check u_frame (
    .sys_clk(sys_clk),
    .rst(rst),
    .take(take),
    .sop(in_sop),
    .eop(in_eop),
    .err_in(in_error),
    .chan_reg(chan),
    .err_code(beat_err)
  );

  // Sop overrides the running count
  wire [`MFS_CH_W-1:0] beat_chan;
  assign beat_chan = in_sop ? `MFS_CH_ZERO : chan; // R11

  // Sticky error across a decimation period, reported with the result
  reg [1:0] err_reg;
  reg [1:0] err_next;
  always @* begin
    err_next = err_reg;
    if (take) begin
      if (dump) begin
        err_next = `MFS_ERR_NONE;
      end else if (beat_err != `MFS_ERR_NONE) begin
        err_next = beat_err; // R6
      end
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      err_reg <= `MFS_ERR_NONE;
    end else begin
      err_reg <= err_next;
    end
  end

  // =====================================================
  // Lanes, interface 0 in the top slice
  genvar g;
  generate
    for (g = 0; g < `MFS_NUM_IF; g = g + 1) begin : lane
      localparam integer ILO = (`MFS_NUM_IF - 1 - g) * `MFS_IN_W;
      localparam integer OLO = (`MFS_NUM_IF - 1 - g) * `MFS_OUT_W;
      wire signed [`MFS_OUT_W-1:0] res;
      mfs_acc_lane u_lane (
        .sys_clk(sys_clk),
        .rst(rst),
        .take(take),
        .dump(dump),
        .chan(beat_chan),
        .sample(combined_input_bus[ILO +: `MFS_IN_W]), // R4 R5
        .result_reg(res)
      );
      assign combined_output_bus[OLO +: `MFS_OUT_W] = res; // R5
    end
  endgenerate

  // =====================================================
  // Source port
  // Lane results and tags load together on a dump beat, held under stall
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      out_valid_reg <= 1'b0; // R22
      out_channel_reg <= `MFS_CH_ZERO;
      out_sop_reg <= 1'b0;
      out_eop_reg <= 1'b0;
      out_error_reg <= `MFS_ERR_NONE;
    end else if (take && dump) begin // R19
      out_valid_reg <= 1'b1;
      out_channel_reg <= beat_chan; // R15
      out_sop_reg <= (beat_chan == `MFS_CH_ZERO); // R16
      out_eop_reg <= (beat_chan == `MFS_CH_LAST); // R17
      out_error_reg <= (beat_err != `MFS_ERR_NONE) ? beat_err : err_reg; // R7
    end else if (out_fire) begin // R3
      out_valid_reg <= 1'b0;
    end
  end

endmodule

// *** verif/mfs_sink_model.sv ***
// Purpose: downstream sink model
// Assumes: changes on the falling edge
// Notes: stall drops ready half the time
`timescale 1ns/1ps
module mfs_sink_model (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Control and ready
  input wire stall,
  output reg out_ready
);
  reg [1:0] cnt_reg;
  always @(negedge sys_clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      out_ready <= !stall || cnt_reg[1];
    end
  end
endmodule

// *** verif/mfs_stream_checker.sv ***
// Purpose: port checks of mfs_stream_top
// Assumes: 4 channels per packet
// Notes: bind follows the module
`timescale 1ns/1ps
module mfs_stream_checker (
  // Clock and reset
  input wire sys_clk,
  input wire rst,
  // Watched ports
  input wire in_valid,
  input wire in_ready,
  input wire [31:0] combined_output_bus,
  input wire [1:0] out_channel_reg,
  input wire out_sop_reg,
  input wire out_eop_reg,
  input wire out_valid_reg,
  input wire out_ready
);
  // ====================
  // Channel owed next
  reg [1:0] nxt_reg;
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      nxt_reg <= 2'h0;
    else if (out_valid_reg && out_ready)
      nxt_reg <= out_channel_reg + 2'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_stall;
    out_valid_reg && !out_ready;
  endsequence
  sequence s_idle_take;
    out_valid_reg && out_ready && !in_valid;
  endsequence
  chk_sop_chan: assert property (
    out_valid_reg |-> out_sop_reg == (out_channel_reg == 2'h0))
    else $error("sop wrong");
  chk_eop_chan: assert property (
    out_valid_reg |-> out_eop_reg == (out_channel_reg == 2'h3))
    else $error("eop wrong");
  chk_hold_stall: assert property (s_stall |=> out_valid_reg &&
    $stable(combined_output_bus) && $stable(out_channel_reg))
    else $error("stalled result moved");
  chk_ready_gate: assert property (
    !in_ready |-> out_valid_reg && !out_ready)
    else $error("ready low without stall");
  chk_reset_idle: assert property (disable iff (1'b0)
    rst |=> !out_valid_reg && out_channel_reg == 2'h0)
    else $error("reset output busy");
  chk_chan_order: assert property (
    out_valid_reg |-> out_channel_reg == nxt_reg)
    else $error("channel out of order");
  chk_valid_cause: assert property (
    $rose(out_valid_reg) |-> $past(in_valid && in_ready))
    else $error("result without beat");
  chk_halt_idle: assert property (s_idle_take |=> !out_valid_reg)
    else $error("result while halted");
endmodule
bind mfs_stream_top mfs_stream_checker i_mfs_stream_checker (
  .sys_clk(sys_clk), .rst(rst), .in_valid(in_valid),
  .in_ready(in_ready), .combined_output_bus(combined_output_bus),
  .out_channel_reg(out_channel_reg), .out_sop_reg(out_sop_reg),
  .out_eop_reg(out_eop_reg), .out_valid_reg(out_valid_reg),
  .out_ready(out_ready));

// *** verif/tb_mfs_stream_top.sv ***
// Purpose: bench of mfs_stream_top
// Assumes: 2 lanes, 4 channels
// Notes: sums checked per channel
`timescale 1ns/1ps
module tb_mfs_stream_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg [2:0] rate = 3'h2;
  reg [31:0] din = 32'h0;
  reg in_valid = 1'b0;
  reg in_sop = 1'b0;
  reg in_eop = 1'b0;
  reg [1:0] in_error = 2'h0;
  reg stall = 1'b0;
  wire in_ready, out_ready, osop, oeop, ovalid;
  wire [31:0] dout;
  wire [1:0] och, oerr;
  reg [15:0] g0 [0:3];
  reg [15:0] g1 [0:3];
  reg [1:0] ge [0:3];
  integer n_got = 0;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer i;
  mfs_stream_top i_mfs_stream_top (.sys_clk(sys_clk), .rst(rst),
    .rate(rate), .combined_input_bus(din), .in_valid(in_valid),
    .in_sop(in_sop), .in_eop(in_eop), .in_error(in_error),
    .in_ready(in_ready), .combined_output_bus(dout),
    .out_channel_reg(och), .out_sop_reg(osop), .out_eop_reg(oeop),
    .out_error_reg(oerr), .out_valid_reg(ovalid), .out_ready(out_ready));
  mfs_sink_model i_mfs_sink_model (.sys_clk(sys_clk), .rst(rst),
    .stall(stall), .out_ready(out_ready));
  initial forever #12.5 sys_clk = ~sys_clk;
  // ====================
  // Capture
  always @(posedge sys_clk) begin
    if (ovalid === 1'b1 && out_ready === 1'b1) begin
      g0[och] <= dout[31:16];
      g1[och] <= dout[15:0];
      ge[och] <= oerr;
      n_got <= n_got + 1;
    end
  end
  task print_verdict;
    begin
      if (n_errors == 0 && samples_checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task cmp_data(input string w, input [15:0] x, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %s exp %h got %h", w, x, g);
      end
    end
  endtask
  task cmp_err(input string w, input [1:0] x, input [1:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %s exp %h got %h", w, x, g);
      end
    end
  endtask
  // Held until ready is seen high at an edge
  task beat(input [15:0] v, input s, input e, input [1:0] er);
    begin
      @(negedge sys_clk);
      din = {v, 16'h0 - v};
      in_sop = s;
      in_eop = e;
      in_error = er;
      in_valid = 1'b1;
      #1;
      while (in_ready !== 1'b1) begin
        @(negedge sys_clk);
        #1;
      end
      @(posedge sys_clk);
    end
  endtask
  task period(input integer r, input [15:0] b, input [1:0] er,
    input s0, input gap, input [2:0] nr);
    integer p, c;
    reg [15:0] e;
    begin
      n_got = 0;
      for (p = 0; p < r; p = p + 1)
        for (c = 0; c < 4; c = c + 1) begin
          if (p == r - 1 && c == 0)
            rate = nr;
          beat(b + c + p, s0 && c == 0, c == 3, er);
          if (gap) begin
            @(negedge sys_clk);
            in_valid = 1'b0;
          end
        end
      @(negedge sys_clk);
      in_valid = 1'b0;
      for (p = 0; p < 40 && n_got < 4; p = p + 1)
        @(negedge sys_clk);
      cmp_data("count", 16'h4, n_got[15:0]);
      for (c = 0; c < 4; c = c + 1) begin
        e = 16'h0;
        for (p = 0; p < r; p = p + 1)
          e = e + b + c + p;
        cmp_data("lane0", e, g0[c]);
        cmp_data("lane1", 16'h0 - e, g1[c]);
        if (s0)
          cmp_err("error", er, ge[c]);
        else
          cmp_err("error", (c == 0) ? 2'h1 : 2'h0, ge[c]);
      end
    end
  endtask
  task mid_reset;
    integer c;
    begin
      for (c = 0; c < 6; c = c + 1)
        beat(16'h0055, c % 4 == 0, c % 4 == 3, 2'h0);
      @(negedge sys_clk);
      in_valid = 1'b0;
      rst = 1'b1;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
    end
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_errors = n_errors + 1;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    period(2, 16'h0100, 2'h0, 1'b1, 1'b0, 3'h3);
    stall = 1'b1;
    period(3, 16'h7FF0, 2'h0, 1'b1, 1'b1, 3'h1);
    stall = 1'b0;
    for (i = 1; i < 4; i = i + 1)
      period(2, 16'h0020, i[1:0], 1'b1, 1'b0, 3'h2);
    period(2, 16'h0010, 2'h0, 1'b0, 1'b0, 3'h2);
    mid_reset;
    period(2, 16'h0200, 2'h0, 1'b1, 1'b0, 3'h2);
    print_verdict;
  end
endmodule
